// ==== hw/slpc_pkg.sv ====
// package: latch layout, field positions and timing for the synthesizer power control
package slpc_pkg;
  localparam int WORD_W = 24;
  localparam logic [1:0] SEL_CONTROL = 2'h0;
  localparam logic [1:0] SEL_REFDIV = 2'h1;
  localparam logic [1:0] SEL_FBDIV = 2'h2;
  localparam logic [1:0] SEL_TEST = 2'h3;
  localparam int LATCH_SEL_LO_POS = 0;
  localparam int PRESCALER_LO_POS = 22;
  localparam int PWRDN_REQUEST_POS = 20;
  localparam int PWRDN_SYNC_MODE_POS = 21;
  localparam int BAND_CYCLES = 5;
  localparam int SYNC_EDGES = 2;
  localparam logic [23:0] WORD_RESET = 24'h000000;

  typedef struct packed {
    logic serialClk;
    logic serialData;
    logic loadStrobe;
  } slpc_link_s;

  typedef struct packed {
    logic poweredDown;
    logic pumpTristate;
    logic rfOutHiZ;
    logic refBufEnable;
    logic countersHeld;
    logic lockDetectClear;
    logic bandSelectActive;
  } slpc_status_s;

  typedef enum logic [1:0] {ST_OFF, ST_RUN, ST_SYNCWAIT, ST_DOWN} slpc_state_e;
endpackage

// ==== hw/slpc_power_control.sv ====
// module: serial latch loading and power-down sequencing for the synthesizer
//
// Behaviour
// R1 - control select zero loads control word
// R2 - prescaler from top two control bits
// R3 - bit21 sync mode, bit20 power-down request
// R4 - async power-down at once on latch
// R5 - sync power-down on second divider edge
// R6 - enable pin low disables immediately
// R7 - power-down removes currents, outputs, ref buffer
// R8 - power-down holds dividers at load state
// R9 - power-down three-states charge pump
// R10 - power-down clears digital lock detect
// R11 - shift register keeps working in power-down
// R12 - host writes reference, control, then feedback
// R13 - first control word powers device up
// R14 - host waits settling before feedback write
// R15 - unchanged feedback word relocks after power-up
// R16 - feedback change in power-down needs resequence
// R17 - 24 bits MSB first, latched on strobe
// R18 - two low bits choose destination latch
// R19 - band select five detector cycles
`timescale 1ns/1ps
`default_nettype none
module slpc_power_control
  import slpc_pkg::*;
(
  input wire logic sys_clk, // 20 MHz system clock
  input wire logic sys_rst, // synchronous reset, high
  input wire slpc_link_s link, // serial clock, data, load strobe pins
  input wire logic chipEnable, // enable pin, low disables
  input wire logic refDivOut, // reference divider output pin
  output logic [23:0] controlWord, // main control latch
  output logic [23:0] feedbackWord, // feedback divider latch
  output logic [23:0] referenceWord, // reference divider latch
  output logic [1:0] prescalerSel, // prescaler modulus select
  output slpc_status_s status // power and loop status
);
  // two-flop synchronisers for all pins
  logic [4:0] syncA_reg, syncB_reg, prev_reg;
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      syncA_reg <= 5'h00;
      syncB_reg <= 5'h00;
      prev_reg <= 5'h00;
    end else begin
      syncA_reg <= {link.serialClk, link.serialData, link.loadStrobe, chipEnable, refDivOut};
      syncB_reg <= syncA_reg;
      prev_reg <= syncB_reg;
    end
  end
  wire sclkRise = syncB_reg[4] & ~prev_reg[4];
  wire sdata = syncB_reg[3];
  wire strobeRise = syncB_reg[2] & ~prev_reg[2];
  wire enPin = syncB_reg[1];
  wire refRise = syncB_reg[0] & ~prev_reg[0];

  logic [23:0] shift_reg;
  always_ff @(posedge sys_clk) begin
    if (sys_rst)
      shift_reg <= WORD_RESET;
    else if (sclkRise)
      shift_reg <= {shift_reg[22:0], sdata}; // see R17 see R11
  end

  wire [1:0] latchSel = shift_reg[LATCH_SEL_LO_POS +: 2];
  wire loadCtl = strobeRise && latchSel == SEL_CONTROL; // see R1 see R18
  wire loadFb = strobeRise && latchSel == SEL_FBDIV; // see R18
  wire loadRef = strobeRise && latchSel == SEL_REFDIV; // see R18
  wire newReq = shift_reg[PWRDN_REQUEST_POS]; // see R3
  wire newSync = shift_reg[PWRDN_SYNC_MODE_POS]; // see R3

  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      controlWord <= WORD_RESET;
      feedbackWord <= WORD_RESET;
      referenceWord <= WORD_RESET;
    end else begin
      if (loadCtl)
        controlWord <= shift_reg; // see R1 see R11
      if (loadFb)
        feedbackWord <= shift_reg;
      if (loadRef)
        referenceWord <= shift_reg;
    end
  end
  assign prescalerSel = controlWord[PRESCALER_LO_POS +: 2]; // see R2

  // power state
  slpc_state_e state_reg, state_next;
  logic [1:0] edgeCnt_reg;
  wire goDownAsync = loadCtl && newReq && !newSync; // see R4
  wire goSync = loadCtl && newReq && newSync; // see R5
  wire goUp = loadCtl && !newReq; // see R13
  // a fresh control word outranks a divider edge in the same cycle
  wire syncDone = state_reg == ST_SYNCWAIT && refRise && !loadCtl && edgeCnt_reg == 2'(SYNC_EDGES - 1);

  always_comb begin
    state_next = state_reg;
    case (state_reg)
      ST_OFF, ST_DOWN: begin
        if (goUp)
          state_next = ST_RUN; // see R13
        else if (goDownAsync || goSync)
          state_next = ST_DOWN; // see R4
      end
      ST_RUN: begin
        if (goDownAsync)
          state_next = ST_DOWN;
        else if (goSync)
          state_next = ST_SYNCWAIT;
      end
      ST_SYNCWAIT: begin
        if (goDownAsync)
          state_next = ST_DOWN;
        else if (goUp)
          state_next = ST_RUN;
        else if (syncDone)
          state_next = ST_DOWN; // see R5
      end
      default: state_next = ST_OFF;
    endcase
  end

  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      state_reg <= ST_OFF;
      edgeCnt_reg <= 2'h0;
    end else begin
      state_reg <= state_next;
      if (state_reg != ST_SYNCWAIT || goSync)
        edgeCnt_reg <= 2'h0;
      else if (refRise)
        edgeCnt_reg <= edgeCnt_reg + 2'h1;
    end
  end

  wire down = !enPin || state_reg == ST_OFF || state_reg == ST_DOWN; // see R6

  // band select after power-up or feedback load; band cleared during power-down
  logic [2:0] band_reg;
  logic wasDown_reg;
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      band_reg <= 3'h0;
      wasDown_reg <= 1'b1;
    end else begin
      wasDown_reg <= down;
      if (down)
        band_reg <= 3'h0;
      else if (loadFb || wasDown_reg)
        band_reg <= 3'(BAND_CYCLES); // see R19 see R15
      else if (refRise && band_reg != 3'h0)
        band_reg <= band_reg - 3'h1;
    end
  end

  assign status.poweredDown = down; // see R7
  assign status.rfOutHiZ = down; // see R7
  assign status.refBufEnable = !down; // see R7
  assign status.countersHeld = down; // see R8
  assign status.pumpTristate = down; // see R9
  assign status.lockDetectClear = down; // see R10
  assign status.bandSelectActive = band_reg != 3'h0;

  // sync power-down steps: armed by the word, then counted divider edges
  sequence syncStartSeq;
    goSync && (state_reg == ST_RUN || state_reg == ST_SYNCWAIT);
  endsequence
  sequence syncFirstEdgeSeq;
    state_reg == ST_SYNCWAIT && refRise && !loadCtl && edgeCnt_reg == 2'h0;
  endsequence

  sync_defer_a: assert property (@(posedge sys_clk) disable iff (sys_rst) // see R5
    syncStartSeq |=> state_reg == ST_SYNCWAIT)
    else $error("sync power-down taken early");
  sync_first_edge_a: assert property (@(posedge sys_clk) disable iff (sys_rst) // see R5
    syncFirstEdgeSeq |=>
      state_reg == ST_SYNCWAIT && edgeCnt_reg == 2'h1)
    else $error("sync power-down on first edge");
  sync_two_edges_a: assert property (@(posedge sys_clk) disable iff (sys_rst) // see R5
    syncDone |=> state_reg == ST_DOWN)
    else $error("sync power-down missed");
  async_down_a: assert property (@(posedge sys_clk) disable iff (sys_rst) // see R4
    goDownAsync |=> state_reg == ST_DOWN)
    else $error("async power-down late");
  powerup_run_a: assert property (@(posedge sys_clk) disable iff (sys_rst) // see R13
    goUp |=> state_reg == ST_RUN)
    else $error("control word did not power up");

  enable_low_a: assert property (@(posedge sys_clk) disable iff (sys_rst) // see R6
    !enPin |-> status.poweredDown && status.pumpTristate)
    else $error("enable low ignored");
  down_outputs_a: assert property (@(posedge sys_clk) disable iff (sys_rst) // see R7
    down |-> status.rfOutHiZ && !status.refBufEnable && status.countersHeld && status.lockDetectClear)
    else $error("power-down outputs not safe");

  ctl_load_a: assert property (@(posedge sys_clk) disable iff (sys_rst) // see R1
    loadCtl |=> controlWord == $past(shift_reg))
    else $error("control word not loaded");
  fb_load_a: assert property (@(posedge sys_clk) disable iff (sys_rst) // see R18
    loadFb |=> feedbackWord == $past(shift_reg))
    else $error("feedback word not loaded");
  ref_load_a: assert property (@(posedge sys_clk) disable iff (sys_rst) // see R18
    loadRef |=> referenceWord == $past(shift_reg))
    else $error("reference word not loaded");
  test_ignored_a: assert property (@(posedge sys_clk) disable iff (sys_rst) // see R18
    strobeRise && latchSel == SEL_TEST |=>
      $stable(controlWord) && $stable(feedbackWord) && $stable(referenceWord))
    else $error("test select touched a latch");
  shift_in_a: assert property (@(posedge sys_clk) disable iff (sys_rst) // see R11
    sclkRise |=> shift_reg[0] == $past(sdata))
    else $error("shift lost bit");
  prescaler_a: assert property (@(posedge sys_clk) disable iff (sys_rst) // see R2
    loadCtl |=> prescalerSel == $past(shift_reg[23:22]))
    else $error("prescaler mismatch");

  band_start_a: assert property (@(posedge sys_clk) disable iff (sys_rst) // see R19
    loadFb && !down ##1 !down |-> band_reg == 3'(BAND_CYCLES))
    else $error("band select not started");
  band_count_a: assert property (@(posedge sys_clk) disable iff (sys_rst) // see R19
    refRise && band_reg != 3'h0 && !down && !loadFb && !wasDown_reg |=>
      band_reg == $past(band_reg) - 3'h1)
    else $error("band select count skipped");
endmodule
`default_nettype wire

// ==== verif/slpc_host_model.sv ====
// host model: shifts 24-bit words into the serial link and strobes them
`timescale 1ns/1ps
`default_nettype none
module slpc_host_model
  import slpc_pkg::*;
(
  input wire logic clk, // system clock
  output var slpc_link_s link // serial clock, data, strobe
);
  initial link = '0;
  // serial clock stands still between frames; 8 clk per bit
  task automatic send(input logic [23:0] w);
    for (int i = 23; i >= 0; i--) begin
      link.serialData <= w[i];
      repeat (4) @(posedge clk);
      link.serialClk <= 1'b1;
      repeat (4) @(posedge clk);
      link.serialClk <= 1'b0;
    end
    repeat (4) @(posedge clk);
    link.serialData <= ~w[0];
    link.loadStrobe <= 1'b1;
    repeat (8) @(posedge clk);
    link.loadStrobe <= 1'b0;
    repeat (8) @(posedge clk);
  endtask
endmodule
`default_nettype wire

// ==== verif/synth_latch_power_control_bench.sv ====
// bench: latch loading and power-down sequencing
`timescale 1ns/1ps
`default_nettype none
module synth_latch_power_control_bench;
  import slpc_pkg::*;
  logic sys_clk, sys_rst, chipEnable, refDivOut;
  slpc_link_s link;
  logic [23:0] controlWord, feedbackWord, referenceWord;
  logic [1:0] prescalerSel;
  slpc_status_s status;
  int errors = 0;
  int check_count = 0;
  localparam int SETTLE_CYCLES = 12000; // 600 us settling at 50 ns
  slpc_host_model host (.clk(sys_clk), .link(link));
  slpc_power_control dut (.sys_clk(sys_clk), .sys_rst(sys_rst), .link(link), .chipEnable(chipEnable),
    .refDivOut(refDivOut), .controlWord(controlWord), .feedbackWord(feedbackWord),
    .referenceWord(referenceWord), .prescalerSel(prescalerSel), .status(status));
  initial begin
    sys_clk = 1'b0;
    forever #25 sys_clk = ~sys_clk;
  end
  task automatic check(input string what, input logic [23:0] seen, input logic [23:0] exp);
    check_count++;
    if (seen !== exp) begin
      errors++;
      $display("MISMATCH %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic down(input logic d);
    check("down", status.poweredDown, d);
    check("pump", status.pumpTristate, d);
    check("rfhiz", status.rfOutHiZ, d);
    check("refbuf", status.refBufEnable, !d);
    check("held", status.countersHeld, d);
    check("lockclr", status.lockDetectClear, d);
  endtask
  task automatic pulse(input int n);
    repeat (n) begin
      repeat (4) @(posedge sys_clk);
      refDivOut <= 1'b1;
      repeat (4) @(posedge sys_clk);
      refDivOut <= 1'b0;
    end
    repeat (6) @(posedge sys_clk);
  endtask
  task automatic t_powerup;
    down(1'b1);
    host.send(24'h000051);
    check("ref", referenceWord, 24'h000051);
    host.send(24'h800004);
    check("ctl", controlWord, 24'h800004);
    check("pre", prescalerSel, 2'h2);
    down(1'b0);
    repeat (SETTLE_CYCLES) @(posedge sys_clk);
    host.send(24'h000F06);
    check("fb", feedbackWord, 24'h000F06);
    check("band", status.bandSelectActive, 1'b1);
  endtask
  task automatic t_testsel;
    host.send(24'h123457);
    check("ctl", controlWord, 24'h800004);
    check("ref", referenceWord, 24'h000051);
    check("fb", feedbackWord, 24'h000F06);
  endtask
  task automatic t_async;
    host.send(24'h900000);
    down(1'b1);
    host.send(24'h000F0E);
    check("fb", feedbackWord, 24'h000F0E);
  endtask
  task automatic t_sync;
    host.send(24'h000051);
    host.send(24'h800000);
    down(1'b0);
    repeat (SETTLE_CYCLES) @(posedge sys_clk);
    host.send(24'h000F0E);
    host.send(24'hB00000);
    pulse(1);
    down(1'b0);
    pulse(1);
    down(1'b1);
  endtask
  task automatic t_enable;
    host.send(24'h800000);
    down(1'b0);
    host.send(24'h000F0A);
    check("band", status.bandSelectActive, 1'b1);
    pulse(4);
    check("band", status.bandSelectActive, 1'b1);
    pulse(1);
    check("band", status.bandSelectActive, 1'b0);
    chipEnable <= 1'b0;
    repeat (4) @(posedge sys_clk);
    down(1'b1);
    chipEnable <= 1'b1;
    repeat (4) @(posedge sys_clk);
    down(1'b0);
    check("band", status.bandSelectActive, 1'b1);
    check("fb", feedbackWord, 24'h000F0A);
  endtask
  task automatic summarize;
    $display("checks %0d errors %0d", check_count, errors);
    if (errors == 0 && check_count > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask
  initial begin
    #2500000; // about twice the expected run
    errors++;
    summarize();
  end
  initial begin
    sys_rst = 1'b1;
    chipEnable = 1'b1;
    refDivOut = 1'b0;
    repeat (10) @(posedge sys_clk);
    sys_rst <= 1'b0;
    repeat (4) @(posedge sys_clk);
    t_powerup();
    t_testsel();
    t_async();
    t_sync();
    t_enable();
    summarize();
  end
endmodule
`default_nettype wire
